// ### qdw_dev.sv
// converter end: samples the three-wire link, decodes the word and keeps
// the four channel registers, the power-down state and its termination.
// assumes link pins are asynchronous to clk_i and sclk is much slower
//
// Our own choices: the placing of the registers and the strobed register port.

`timescale 1ns/1ps

// Function
// - reset clears registers, outputs zero
// - mode 11 means power-down, no load
// - power-down termination chosen by channel bits
// - power-down applies to all channels
// - power-down keeps stored channel codes
// - wake-up restores held codes unless rewritten
// - sync falling edge starts a word
// - sample data on falling sclk while sync low
// - host never drops sync with sclk falling
// - sixteenth falling edge executes command
// - ignore clocks after sixteenth until sync high
// - host holds sync high minimum before frame
// - host parks sync and data low
// - word is address, mode, then data
// - four modes: load, load-update, all, power-down
// - data MSB first, straight binary
// - early sync rise abandons the word
// - channel code unsigned 0 to 4095
// - byte hosts keep sync low, MSB first
// - dsp host internal clock, low framing, 16-bit
// - host stops sclk during power-down
module qdw_dev #(
  parameter int WAKE_CYC = qdw_pkg::WAKE_UP_CYC
) (
  // clock and reset
  input  wire logic                                      clk_i,
  input  wire logic                                      rst_n_i,
  // link
  qdw_link_if.dev                                        link,
  // channel codes driving the outputs
  output logic [qdw_pkg::NUM_CHAN-1:0][qdw_pkg::CODE_BITS-1:0] dac_code_o,
  // power state
  output logic                                           pd_o,
  output qdw_pkg::qdw_term_t                             pd_term_o,
  output logic                                           out_ready_o,
  // frame events
  output logic                                           word_o,
  output logic                                           abort_o
);
  import qdw_pkg::*;

  // ----------------------------------------------------------------
  // pin synchronisers and edge detect
  // ----------------------------------------------------------------
  logic [2:0] pin_s1;
  logic [2:0] pin_s2;
  logic       sync_d;
  logic       sclk_d;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pin_s1 <= 3'h0;
      pin_s2 <= 3'h0;
      sync_d <= 1'b0;
      sclk_d <= 1'b0;
    end
    else
    begin
      pin_s1 <= {link.sync_n, link.sclk, link.din};
      pin_s2 <= pin_s1;
      sync_d <= pin_s2[2];
      sclk_d <= pin_s2[1];
    end
  end

  wire sync_s    = pin_s2[2];
  wire sclk_s    = pin_s2[1];
  wire din_s     = pin_s2[0];
  wire sync_fall = sync_d & ~sync_s;
  wire sync_rise = ~sync_d & sync_s;
  wire sclk_fall = sclk_d & ~sclk_s;

  // ----------------------------------------------------------------
  // frame tracker
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    F_IDLE  = 2'b00,
    F_SHIFT = 2'b01,
    F_DONE  = 2'b10
  } qdw_fstate_t;

  qdw_fstate_t          state;
  qdw_fstate_t          next_state;
  logic [3:0]           bit_cnt;
  logic [WORD_BITS-2:0] shreg;

  // a sync drop seen with a falling sclk restarts the word and drops that edge
  wire take_bit = (state == F_SHIFT) & sclk_fall & ~sync_s & ~sync_fall;
  wire exec     = take_bit & (bit_cnt == LAST_BIT);
  wire early_up = (state == F_SHIFT) & sync_s & (bit_cnt != 4'h0);

  always_comb
  begin
    next_state = state;
    case (state)
      F_IDLE:
        if (sync_fall)
          next_state = F_SHIFT;
      F_SHIFT:
        if (sync_s)
          next_state = F_IDLE;
        else if (exec)
          next_state = F_DONE;
      F_DONE:
        if (sync_s)
          next_state = F_IDLE;
      default:
        next_state = F_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state   <= F_IDLE;
      bit_cnt <= 4'h0;
      shreg   <= '0;
    end
    else
    begin
      state <= next_state;
      if (sync_fall)
        bit_cnt <= 4'h0;
      else if (take_bit)
      begin
        bit_cnt <= bit_cnt + 4'h1;
        shreg   <= {shreg[WORD_BITS-3:0], din_s};
      end
    end
  end

  // ----------------------------------------------------------------
  // word decode
  // ----------------------------------------------------------------
  wire [WORD_BITS-1:0] word     = {shreg, din_s};
  wire [1:0]           w_addr   = word[ADDR_MSB:ADDR_LSB];
  wire [1:0]           w_mode   = word[MODE_MSB:MODE_LSB];
  wire [CODE_BITS-1:0] w_data   = word[DATA_MSB:0];
  wire                 is_pd    = (w_mode == QDW_PWR_DOWN);
  wire                 is_load  = (w_mode == QDW_LOAD_ONLY);
  wire                 is_upd   = (w_mode == QDW_LOAD_UPD);
  wire                 is_all   = (w_mode == QDW_LOAD_ALL);
  wire                 do_load  = exec & ~is_pd;
  wire                 do_pd    = exec & is_pd;
  // both 00 and 11 mean high impedance
  wire [1:0]           term_sel = (w_addr == QDW_CH_D) ? QDW_TERM_HIZ : w_addr;

  // ----------------------------------------------------------------
  // channel registers
  // ----------------------------------------------------------------
  // input registers hold a mode-00 load until an update copies them across
  logic [CODE_BITS-1:0] in_reg  [NUM_CHAN];
  logic [CODE_BITS-1:0] dac_reg [NUM_CHAN];

  genvar ch;
  generate
    for (ch = 0; ch < NUM_CHAN; ch++)
    begin : g_chan
      wire                 hit      = (w_addr == 2'(ch));
      wire                 ld_in    = do_load & ((hit & (is_load | is_upd)) | is_all);
      wire                 ld_dac   = do_load & (is_upd | is_all);
      wire [CODE_BITS-1:0] next_in  = ld_in ? w_data : in_reg[ch];
      wire [CODE_BITS-1:0] next_dac = ld_dac ? next_in : dac_reg[ch];

      always_ff @(posedge clk_i or negedge rst_n_i)
      begin
        if (!rst_n_i)
        begin
          in_reg[ch]  <= CODE_RST;
          dac_reg[ch] <= CODE_RST;
        end
        else
        begin
          // power-down words never reach these registers
          in_reg[ch]  <= next_in;
          dac_reg[ch] <= next_dac;
        end
      end

      assign dac_code_o[ch] = dac_reg[ch];
    end
  endgenerate

  // ----------------------------------------------------------------
  // power-down and wake-up
  // ----------------------------------------------------------------
  // any completed load word wakes the outputs; held codes come back when out_ready_o rises WAKE_CYC clocks later
  logic [7:0] wake_cnt;
  qdw_term_t  term;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pd_o     <= 1'b0;
      term     <= QDW_TERM_HIZ;
      wake_cnt <= 8'h00;
      word_o   <= 1'b0;
      abort_o  <= 1'b0;
    end
    else
    begin
      word_o  <= exec;
      abort_o <= early_up;
      if (do_pd)
      begin
        pd_o     <= 1'b1;
        term     <= qdw_term_t'(term_sel);
        wake_cnt <= 8'h00;
      end
      else if (do_load & pd_o)
      begin
        pd_o     <= 1'b0;
        wake_cnt <= 8'(WAKE_CYC);
      end
      else if (wake_cnt != 8'h00)
        wake_cnt <= wake_cnt - 8'h01;
    end
  end

  assign pd_term_o   = term;
  assign out_ready_o = ~pd_o & (wake_cnt == 8'h00);

endmodule // qdw_dev

// ### qdw_pkg.sv
// shared constants and types for the quad converter serial write path
// assumes a 20 MHz system clock on both ends of the three-wire link

package qdw_pkg;

  // ----------------------------------------------------------------
  // clock and link timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 50;
  localparam int SCLK_PERIOD_NS  = 400;
  localparam int SCLK_HALF_CYC   = ((SCLK_PERIOD_NS / 2) + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SYNC_HIGH_NS    = 10;
  localparam int SYNC_HIGH_CYC   = (SYNC_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_UP_TIME_NS = 6000;
  localparam int WAKE_UP_CYC     = (WAKE_UP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // word layout
  // ----------------------------------------------------------------
  localparam int       WORD_BITS = 16;
  localparam int       CODE_BITS = 12;
  localparam int       NUM_CHAN  = 4;
  localparam int       ADDR_MSB  = 15;
  localparam int       ADDR_LSB  = 14;
  localparam int       MODE_MSB  = 13;
  localparam int       MODE_LSB  = 12;
  localparam int       DATA_MSB  = 11;
  localparam logic [3:0] LAST_BIT = 4'hf;
  localparam logic [11:0] CODE_RST = 12'h000;

  typedef enum logic [1:0] {
    QDW_CH_A = 2'b00,
    QDW_CH_B = 2'b01,
    QDW_CH_C = 2'b10,
    QDW_CH_D = 2'b11
  } qdw_chan_t;

  typedef enum logic [1:0] {
    QDW_LOAD_ONLY = 2'b00,
    QDW_LOAD_UPD  = 2'b01,
    QDW_LOAD_ALL  = 2'b10,
    QDW_PWR_DOWN  = 2'b11
  } qdw_mode_t;

  typedef enum logic [1:0] {
    QDW_TERM_HIZ  = 2'b00,
    QDW_TERM_2K5  = 2'b01,
    QDW_TERM_100K = 2'b10
  } qdw_term_t;

endpackage

// ### qdw_link_if.sv
// three-wire write link between the host serial master and the converter
// assumes both ends sit in one clock domain of the bench; pins are one-way

`timescale 1ns/1ps

interface qdw_link_if;
  logic sync_n;
  logic sclk;
  logic din;

  modport host (
    output sync_n,
    output sclk,
    output din
  );

  modport dev (
    input  sync_n,
    input  sclk,
    input  din
  );
endinterface

// ### qdw_host.sv
// host serial master: turns one word request into a framed 16-bit write
// assumes the converter samples din on falling sclk while sync_n is low

`timescale 1ns/1ps

module qdw_host #(
  parameter int SCLK_HALF = qdw_pkg::SCLK_HALF_CYC
) (
  // clock and reset
  input  wire logic                         clk_i,
  input  wire logic                         rst_n_i,
  // link
  qdw_link_if.host                          link,
  // user request
  input  wire logic                         req_i,
  input  wire logic [1:0]                   addr_i,
  input  wire logic [1:0]                   mode_i,
  input  wire logic [qdw_pkg::CODE_BITS-1:0] data_i,
  output logic                              ready_o,
  output logic                              done_o
);
  import qdw_pkg::*;

  // ----------------------------------------------------------------
  // state and timing
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    H_IDLE    = 3'b000,
    H_SYNC_HI = 3'b001,
    H_SETUP   = 3'b010,
    H_CLK_HI  = 3'b011,
    H_CLK_LO  = 3'b100,
    H_TAIL    = 3'b101
  } qdw_hstate_t;

  // sync high time is at least one sclk half, which also covers its own minimum
  localparam int HI_CYC = (SCLK_HALF > SYNC_HIGH_CYC) ? SCLK_HALF : SYNC_HIGH_CYC;

  qdw_hstate_t          state;
  logic [7:0]           tmr;
  logic [3:0]           bit_cnt;
  logic [WORD_BITS-1:0] shreg;
  logic                 sync_n;
  logic                 sclk;
  logic                 din;

  wire tmr_done = (tmr == 8'h00);
  wire last_bit = (bit_cnt == LAST_BIT);

  assign ready_o     = (state == H_IDLE);
  assign link.sync_n = sync_n;
  assign link.sclk   = sclk;
  assign link.din    = din;

  // ----------------------------------------------------------------
  // frame sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state   <= H_IDLE;
      tmr     <= 8'h00;
      bit_cnt <= 4'h0;
      shreg   <= '0;
      sync_n  <= 1'b0;
      sclk    <= 1'b0;
      din     <= 1'b0;
      done_o  <= 1'b0;
    end
    else
    begin
      done_o <= 1'b0;
      if (!tmr_done)
        tmr <= tmr - 8'h01;
      case (state)
        H_IDLE:
        begin
          if (req_i)
          begin
            shreg  <= {addr_i, mode_i, data_i};
            sync_n <= 1'b1;
            tmr    <= 8'(HI_CYC - 1);
            state  <= H_SYNC_HI;
          end
        end
        H_SYNC_HI:
          if (tmr_done)
          begin
            sync_n  <= 1'b0;
            bit_cnt <= 4'h0;
            tmr     <= 8'(SCLK_HALF - 1);
            state   <= H_SETUP;
          end
        H_SETUP:
          if (tmr_done)
          begin
            sclk  <= 1'b1;
            din   <= shreg[WORD_BITS-1];
            shreg <= {shreg[WORD_BITS-2:0], 1'b0};
            tmr   <= 8'(SCLK_HALF - 1);
            state <= H_CLK_HI;
          end
        H_CLK_HI:
          if (tmr_done)
          begin
            sclk  <= 1'b0;
            tmr   <= 8'(SCLK_HALF - 1);
            state <= H_CLK_LO;
          end
        H_CLK_LO:
          if (tmr_done)
          begin
            tmr <= 8'(SCLK_HALF - 1);
            if (last_bit)
              state <= H_TAIL;
            else
            begin
              bit_cnt <= bit_cnt + 4'h1;
              sclk    <= 1'b1;
              din     <= shreg[WORD_BITS-1];
              shreg   <= {shreg[WORD_BITS-2:0], 1'b0};
              state   <= H_CLK_HI;
            end
          end
        H_TAIL:
          if (tmr_done)
          begin
            // park sync and data low, clock stopped
            din    <= 1'b0;
            done_o <= 1'b1;
            state  <= H_IDLE;
          end
        default:
          state <= H_IDLE;
      endcase
    end
  end

endmodule // qdw_host

// ### qdw_props.sv
// concurrent checks on the host-to-converter link and the converter status
// assumes sclk half period of four clocks and one clock domain for all inputs

`timescale 1ns/1ps

module qdw_props (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // link
  input  wire logic sync_n,
  input  wire logic sclk,
  input  wire logic din,
  // end-point status
  input  wire logic done_o,
  input  wire logic word_o,
  input  wire logic pd_o,
  input  wire logic out_ready_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  // ----------------------------------------------------------------
  // falling sclk edges in the current frame
  // ----------------------------------------------------------------
  logic [4:0] n_fall;
  always_ff @(posedge clk_i or negedge rst_n_i)
    if (!rst_n_i)
      n_fall <= 5'h00;
    else if (sync_n)
      n_fall <= 5'h00;
    else if ($fell(sclk))
      n_fall <= n_fall + 5'h01;

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  chk_sync_clk_apart: assert property ($fell(sync_n) |-> !$fell(sclk))
    else $error("sync fell together with sclk");
  chk_park_low: assert property (done_o |-> !sync_n && !din && !sclk)
    else $error("link not parked low after a word");
  chk_sclk_high_len: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
    else $error("sclk high phase wrong");
  chk_sclk_low_len: assert property ($fell(sclk) |-> !sclk [*4])
    else $error("sclk low phase too short");
  chk_din_at_fall: assert property ($fell(sclk) |-> $stable(din))
    else $error("din moved at the sampling edge");
  chk_word_count: assert property (word_o |-> n_fall == 5'h10)
    else $error("word executed without sixteen edges");
  chk_word_after_16: assert property (($fell(sclk) && !sync_n && n_fall == 5'h0f)
    |-> ##[1:6] word_o)
    else $error("sixteenth edge not executed");
  chk_pd_by_word: assert property ($changed(pd_o) |-> word_o)
    else $error("power state moved without a word");
  chk_pd_not_ready: assert property (pd_o |-> !out_ready_o)
    else $error("outputs ready while powered down");
  chk_wake_ready: assert property ($fell(pd_o) |-> !out_ready_o ##[1:8] out_ready_o)
    else $error("wake-up time not kept");

  cover property ($rose(pd_o));
  cover property ($fell(pd_o));
  cover property (word_o);
endmodule // qdw_props

// ### quad_dac_serial_write_control_tb.sv
// self-checking bench: host end to one converter, raw driver to a second
// assumes 20 MHz clock and the default sclk half period of four clocks

`timescale 1ns/1ps

module quad_dac_serial_write_control_tb;
  import qdw_pkg::*;
  logic             clk_i = 1'b0;
  logic             rst_n_i = 1'b0;
  logic             req_i = 1'b0;
  logic [1:0]       addr_i = 2'h0;
  logic [1:0]       mode_i = 2'h0;
  logic [11:0]      data_i = 12'h000;
  logic             ready_o, done_o, pd_o, out_ready_o, word_o, abort_o;
  logic             pd2, rdy2, word2, abort2;
  qdw_term_t        pd_term_o, term2;
  logic [3:0][11:0] dac_code_o, code2, exp_code;
  int               miscompares = 0;
  int               n_tests = 0;
  int               n_word2 = 0;
  int               n_abort2 = 0;
  int               n_abort1 = 0;

  // ----------------------------------------------------------------
  // ends, links and checker
  // ----------------------------------------------------------------
  qdw_link_if link1 ();
  qdw_link_if link2 ();
  always #25 clk_i = ~clk_i;
  qdw_host qdw_host_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .link(link1.host), .req_i(req_i),
    .addr_i(addr_i), .mode_i(mode_i), .data_i(data_i), .ready_o(ready_o), .done_o(done_o));
  qdw_dev #(.WAKE_CYC(4)) qdw_dev_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .link(link1.dev),
    .dac_code_o(dac_code_o), .pd_o(pd_o), .pd_term_o(pd_term_o), .out_ready_o(out_ready_o),
    .word_o(word_o), .abort_o(abort_o));
  // second converter faces a raw driver that can break frames on purpose
  qdw_dev #(.WAKE_CYC(4)) qdw_dev2_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .link(link2.dev),
    .dac_code_o(code2), .pd_o(pd2), .pd_term_o(term2), .out_ready_o(rdy2),
    .word_o(word2), .abort_o(abort2));
  qdw_props qdw_props_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .sync_n(link1.sync_n),
    .sclk(link1.sclk), .din(link1.din), .done_o(done_o), .word_o(word_o), .pd_o(pd_o),
    .out_ready_o(out_ready_o));

  always @(posedge clk_i)
  begin
    if (word2 === 1'b1) n_word2 <= n_word2 + 1;
    if (abort2 === 1'b1) n_abort2 <= n_abort2 + 1;
    if (abort_o === 1'b1) n_abort1 <= n_abort1 + 1;
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic chk_codes(input logic [3:0][11:0] seen, input logic [3:0][11:0] exp);
    for (int c = 0; c < 4; c++)
      check("code", {4'h0, seen[c]}, {4'h0, exp[c]});
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic hsend(input logic [1:0] a, input logic [1:0] m, input logic [11:0] d);
    int n;
    @(posedge clk_i);
    req_i <= 1'b1;
    addr_i <= a;
    mode_i <= m;
    data_i <= d;
    @(posedge clk_i);
    req_i <= 1'b0;
    @(negedge clk_i);
    check("busy", {15'h0, ready_o}, 16'h0000);
    n = 0;
    while (done_o !== 1'b1 && n < 400)
    begin
      @(negedge clk_i);
      n++;
    end
    check("done", {15'h0, done_o}, 16'h0001);
    check("idle", {15'h0, ready_o}, 16'h0001);
  endtask

  // raw frame: nb word bits, then extra clocks of ones before sync rises
  task automatic rsend(input logic [15:0] w, input int nb, input int extra);
    link2.sync_n <= 1'b1;
    repeat (4) @(posedge clk_i);
    link2.sync_n <= 1'b0;
    repeat (4) @(posedge clk_i);
    for (int i = 0; i < nb + extra; i++)
    begin
      link2.din <= (i < nb) ? w[15 - i] : 1'b1;
      link2.sclk <= 1'b1;
      repeat (4) @(posedge clk_i);
      link2.sclk <= 1'b0;
      repeat (4) @(posedge clk_i);
    end
    link2.sync_n <= 1'b1;
    link2.din <= 1'b0;
    repeat (8) @(posedge clk_i);
    link2.sync_n <= 1'b0;
    @(negedge clk_i);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    exp_code = '0;
    chk_codes(dac_code_o, exp_code);
    check("pd", {15'h0, pd_o}, 16'h0000);
    check("ready", {15'h0, out_ready_o}, 16'h0001);
  endtask

  task automatic t_modes();
    for (int c = 0; c < 4; c++)
      hsend(2'(c), QDW_LOAD_ONLY, 12'h3a0 + 12'(c));
    chk_codes(dac_code_o, exp_code);
    hsend(QDW_CH_A, QDW_LOAD_UPD, 12'hfff);
    exp_code = {12'h3a3, 12'h3a2, 12'h3a1, 12'hfff};
    chk_codes(dac_code_o, exp_code);
    hsend(QDW_CH_D, QDW_LOAD_ALL, 12'h801);
    exp_code = {4{12'h801}};
    chk_codes(dac_code_o, exp_code);
  endtask

  task automatic t_pd();
    for (int t = 0; t < 4; t++)
    begin
      hsend(2'(t), QDW_PWR_DOWN, 12'hfff);
      check("pd", {15'h0, pd_o}, 16'h0001);
      check("term", {14'h0, pd_term_o}, (t == 3) ? 16'h0000 : 16'(t));
      check("ready", {15'h0, out_ready_o}, 16'h0000);
      chk_codes(dac_code_o, exp_code);
    end
    hsend(QDW_CH_C, QDW_LOAD_UPD, 12'h0ab);
    exp_code[2] = 12'h0ab;
    check("pd", {15'h0, pd_o}, 16'h0000);
    chk_codes(dac_code_o, exp_code);
    repeat (10) @(negedge clk_i);
    check("ready", {15'h0, out_ready_o}, 16'h0001);
    check("aborts1", 16'(n_abort1), 16'h0000);
  endtask

  task automatic t_abort();
    rsend({QDW_CH_A, QDW_LOAD_ALL, 12'habc}, 16, 0);
    chk_codes(code2, {4{12'habc}});
    rsend({QDW_CH_B, QDW_LOAD_ALL, 12'h123}, 15, 0);
    rsend({QDW_CH_B, QDW_PWR_DOWN, 12'h000}, 4, 0);
    chk_codes(code2, {4{12'habc}});
    check("pd2", {15'h0, pd2}, 16'h0000);
    check("ready2", {15'h0, rdy2}, 16'h0001);
    check("term2", {14'h0, term2}, 16'h0000);
    check("aborts", 16'(n_abort2), 16'h0002);
    check("words", 16'(n_word2), 16'h0001);
  endtask

  task automatic t_extra();
    rsend({QDW_CH_B, QDW_LOAD_ALL, 12'h5a5}, 16, 8);
    chk_codes(code2, {4{12'h5a5}});
    check("words", 16'(n_word2), 16'h0002);
    check("aborts", 16'(n_abort2), 16'h0002);
  endtask

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    link2.sync_n = 1'b0;
    link2.sclk = 1'b0;
    link2.din = 1'b0;
    repeat (16) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (2) @(negedge clk_i);
    t_reset();
    t_modes();
    t_pd();
    @(posedge clk_i);
    t_abort();
    @(posedge clk_i);
    t_extra();
    end_sim();
  end

  initial
  begin
    repeat (20000) @(posedge clk_i);
    miscompares++;
    end_sim();
  end
endmodule // quad_dac_serial_write_control_tb
